// ===== logic/pfid_inst_field.sv
// Per-instance, per-page field lookup for one instance-specific ID field
`timescale 1ns/10ps
`default_nettype none
module pfid_inst_field
	import pfid_pkg::*;
#(
	parameter int NUM_INST = 1,
	parameter int FIELD_W = 6,
	parameter logic [NUM_INST*FIELD_W-1:0] VAL_SECURE = '0,
	parameter logic [NUM_INST*FIELD_W-1:0] VAL_NONSECURE = '0
) (
	input wire logic secure_i,
	input wire logic [PFID_SEL_W-1:0] sel_i,
	output logic [FIELD_W-1:0] field_o
);
	// Missing instances report zero, like a removed instance would
	always_comb begin
		field_o = '0;
		if (int'(sel_i) < NUM_INST) begin
			if (secure_i) begin
				field_o = VAL_SECURE[int'(sel_i)*FIELD_W +: FIELD_W];
			end else begin
				field_o = VAL_NONSECURE[int'(sel_i)*FIELD_W +: FIELD_W];
			end
		end
	end
endmodule : pfid_inst_field
`default_nettype wire

// ===== logic/pfid_pkg.sv
// Shared offsets, field layouts and bus carriers of the partition feature ID bank
package pfid_pkg;
	localparam int PFID_ADDR_W = 12;
	localparam int PFID_DATA_W = 32;
	localparam int PFID_SEL_W = 4;
	localparam int PFID_CAP_W = 6;
	localparam int PFID_POR_W = 16;
	localparam int PFID_REV_W = 4;
	localparam int PFID_CNT_W = 11;

	// Byte offsets within each feature page
	localparam logic [PFID_ADDR_W-1:0] PFID_ARCH_VERSION_ID_OFS = 12'h020;
	localparam logic [PFID_ADDR_W-1:0] PFID_CACHE_PORTION_FEATURE_ID_OFS = 12'h030;
	localparam logic [PFID_ADDR_W-1:0] PFID_CACHE_CAPACITY_FEATURE_ID_OFS = 12'h038;

	// Field positions
	localparam int PFID_MAJOR_LSB = 4;
	localparam int PFID_MINOR_LSB = 0;
	localparam int PFID_CAP_LSB = 0;
	localparam int PFID_POR_LSB = 0;

	// Legal field ranges and bitmap grouping
	localparam int PFID_CAP_MIN = 1;
	localparam int PFID_CAP_MAX = 16;
	localparam int PFID_POR_MIN = 1;
	localparam int PFID_POR_MAX = 32768;
	localparam int PFID_BITMAP_WORD = 32;
	localparam int PFID_BITMAP_REGS_MAX = 1024;

	// Values after reset
	localparam logic [PFID_DATA_W-1:0] PFID_RDATA_RST = 32'h0000_0000;
	localparam logic [PFID_CNT_W-1:0] PFID_CNT_RST = 11'h000;

	// Register access request, one cycle per access
	typedef struct packed {
		logic valid;
		logic write;
		logic secure;
		logic [PFID_ADDR_W-1:0] addr;
		logic [PFID_DATA_W-1:0] wdata;
	} pfid_req_t;

	// Register access answer
	typedef struct packed {
		logic ack;
		logic [PFID_DATA_W-1:0] rdata;
	} pfid_rsp_t;
endpackage : pfid_pkg

// ===== logic/pfid_regs.sv
// Read-only partition feature identification registers with banked pages
// Contract
// - The version register is 32 bits, bits 31:8 read zero and bits 7:4 hold the major revision.
// - Bits 3:0 hold the minor revision and the pair must be a defined valid combination.
// - Forced non-secure partition behaviour exists only for the restricted earliest version.
// - That version issues secure requests with partition id forced non-secure, invisible to software.
// - The version register is read-only and reads the same from secure and non-secure pages.
// - Both a secure and a non-secure feature page exist and hold the ID registers.
// - Without the partitioning extension the version register reads zero.
// - The capacity ID register exists only when capacity partitioning is present, else reads zero.
// - Capacity bits 5:0 give fractional width 1 to 16 and bits 31:6 read zero.
// - With instances present, instance fields follow the instance selector, others stay constant.
// - Capacity and portion ID registers are read-only, readable from both pages, banked if different.
// - The portion ID register exists only when portion partitioning is present, else reads zero.
// - Portion bits 15:0 give bitmap width 1 to 32768 and bits 31:16 read zero.
// - Bitmaps wider than 32 bits span consecutive 32-bit registers, at most 1024.
`timescale 1ns/10ps
`default_nettype none
module pfid_regs
	import pfid_pkg::*;
#(
	parameter bit PART_PRESENT = 1'b1,
	parameter bit CAP_PRESENT = 1'b1,
	parameter bit POR_PRESENT = 1'b1,
	parameter bit INST_PRESENT = 1'b0,
	parameter int NUM_INST = 1,
	// Revision defaults are arbitrary picks among the valid pairs
	parameter logic [PFID_REV_W-1:0] MAJOR_REV = 4'h1,
	parameter logic [PFID_REV_W-1:0] MINOR_REV = 4'h0,
	parameter logic [NUM_INST*PFID_CAP_W-1:0] CAP_WD_SECURE = {NUM_INST{6'h08}},
	parameter logic [NUM_INST*PFID_CAP_W-1:0] CAP_WD_NONSECURE = {NUM_INST{6'h08}},
	parameter logic [NUM_INST*PFID_POR_W-1:0] POR_WD_SECURE = {NUM_INST{16'h0010}},
	parameter logic [NUM_INST*PFID_POR_W-1:0] POR_WD_NONSECURE = {NUM_INST{16'h0010}}
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire pfid_req_t req_i,
	input wire logic [PFID_SEL_W-1:0] resource_instance_selector_i,
	output pfid_rsp_t rsp_o,
	output logic force_nonsecure_partition_o,
	output logic [PFID_CNT_W-1:0] bitmap_reg_count_o
);
	// Valid version pairs: none, early restricted, base, extended
	localparam bit VER_EARLY = (MAJOR_REV == 4'h0) && (MINOR_REV == 4'h1);
	localparam bit VER_VALID = VER_EARLY || (MAJOR_REV == 4'h1) && (MINOR_REV <= 4'h1)
		|| (MAJOR_REV == 4'h0) && (MINOR_REV == 4'h0);

	// Refuse configurations the bank cannot describe honestly
	function automatic bit fields_ok();
		bit ok;
		ok = 1'b1;
		for (int i = 0; i < NUM_INST; i++) begin
			if (int'(CAP_WD_SECURE[i*PFID_CAP_W +: PFID_CAP_W]) < PFID_CAP_MIN
				|| int'(CAP_WD_SECURE[i*PFID_CAP_W +: PFID_CAP_W]) > PFID_CAP_MAX
				|| int'(CAP_WD_NONSECURE[i*PFID_CAP_W +: PFID_CAP_W]) < PFID_CAP_MIN
				|| int'(CAP_WD_NONSECURE[i*PFID_CAP_W +: PFID_CAP_W]) > PFID_CAP_MAX
				|| int'(POR_WD_SECURE[i*PFID_POR_W +: PFID_POR_W]) < PFID_POR_MIN
				|| int'(POR_WD_SECURE[i*PFID_POR_W +: PFID_POR_W]) > PFID_POR_MAX
				|| int'(POR_WD_NONSECURE[i*PFID_POR_W +: PFID_POR_W]) < PFID_POR_MIN
				|| int'(POR_WD_NONSECURE[i*PFID_POR_W +: PFID_POR_W]) > PFID_POR_MAX) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction : fields_ok

	if (!VER_VALID) begin : g_bad_version
		$error("pfid_regs: revision pair is not a valid combination");
	end
	if (!fields_ok()) begin : g_bad_fields
		$error("pfid_regs: capacity or bitmap width out of range");
	end
	if (NUM_INST < 1 || NUM_INST > (1 << PFID_SEL_W)) begin : g_bad_inst
		$error("pfid_regs: instance count not servable by the selector");
	end

	logic [PFID_SEL_W-1:0] sel_eff;
	logic [PFID_CAP_W-1:0] cap_wd;
	logic [PFID_POR_W-1:0] por_wd;
	logic [PFID_POR_W-1:0] por_wd_sec;
	logic [PFID_DATA_W-1:0] rdata_next;
	logic [PFID_CNT_W-1:0] count_next;
	logic ack_reg;
	logic [PFID_DATA_W-1:0] rdata_reg;
	logic force_reg;
	logic [PFID_CNT_W-1:0] count_reg;

	// Without instances the selector is meaningless, so instance zero is shown
	assign sel_eff = INST_PRESENT ? resource_instance_selector_i : '0;

	// Bank for the page of the current access
	pfid_inst_field #(
		.NUM_INST(NUM_INST),
		.FIELD_W(PFID_CAP_W),
		.VAL_SECURE(CAP_WD_SECURE),
		.VAL_NONSECURE(CAP_WD_NONSECURE)
	) u_cap (
		.secure_i(req_i.secure),
		.sel_i(sel_eff),
		.field_o(cap_wd)
	);

	pfid_inst_field #(
		.NUM_INST(NUM_INST),
		.FIELD_W(PFID_POR_W),
		.VAL_SECURE(POR_WD_SECURE),
		.VAL_NONSECURE(POR_WD_NONSECURE)
	) u_por (
		.secure_i(req_i.secure),
		.sel_i(sel_eff),
		.field_o(por_wd)
	);

	// Secure-page bitmap width, which the portion bitmap group follows
	pfid_inst_field #(
		.NUM_INST(NUM_INST),
		.FIELD_W(PFID_POR_W),
		.VAL_SECURE(POR_WD_SECURE),
		.VAL_NONSECURE(POR_WD_SECURE)
	) u_por_grp (
		.secure_i(1'b1),
		.sel_i(sel_eff),
		.field_o(por_wd_sec)
	);

	// Read decode; both pages share one decoder, banking is in the lookups
	always_comb begin
		rdata_next = PFID_RDATA_RST;
		if (req_i.valid && !req_i.write) begin
			unique case (req_i.addr)
				PFID_ARCH_VERSION_ID_OFS: begin
					if (PART_PRESENT) begin
						rdata_next[PFID_MAJOR_LSB +: PFID_REV_W] = MAJOR_REV;
						rdata_next[PFID_MINOR_LSB +: PFID_REV_W] = MINOR_REV;
					end
				end
				PFID_CACHE_CAPACITY_FEATURE_ID_OFS: begin
					if (PART_PRESENT && CAP_PRESENT) begin
						rdata_next[PFID_CAP_LSB +: PFID_CAP_W] = cap_wd;
					end
				end
				PFID_CACHE_PORTION_FEATURE_ID_OFS: begin
					if (PART_PRESENT && POR_PRESENT) begin
						rdata_next[PFID_POR_LSB +: PFID_POR_W] = por_wd;
					end
				end
				default: rdata_next = PFID_RDATA_RST;
			endcase
		end
	end

	// Number of 32-bit words the selected bitmap occupies
	assign count_next = (PART_PRESENT && POR_PRESENT)
		? PFID_CNT_W'((32'(por_wd_sec) + PFID_BITMAP_WORD - 1) / PFID_BITMAP_WORD)
		: PFID_CNT_RST;

	// Answer one cycle after every access, writes included
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_reg <= 1'b0;
			rdata_reg <= PFID_RDATA_RST;
		end else begin
			ack_reg <= req_i.valid;
			rdata_reg <= rdata_next;
		end
	end

	// Forcing is fixed by the version and has no software control or status bit
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			force_reg <= 1'b0;
		end else begin
			force_reg <= PART_PRESENT && VER_EARLY;
		end
	end

	// Bitmap group size tracks the selector
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_reg <= PFID_CNT_RST;
		end else begin
			count_reg <= count_next;
		end
	end

	assign rsp_o.ack = ack_reg;
	assign rsp_o.rdata = rdata_reg;
	assign force_nonsecure_partition_o = force_reg;
	assign bitmap_reg_count_o = count_reg;

	// Checks on the answers
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_read(logic [PFID_ADDR_W-1:0] ofs);
		req_i.valid && !req_i.write && req_i.addr == ofs;
	endsequence

	property p_ack_next;
		req_i.valid |=> rsp_o.ack;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("access not answered");

	property p_no_spurious_ack;
		!req_i.valid |=> !rsp_o.ack;
	endproperty
	a_no_spurious_ack: assert property (p_no_spurious_ack) else $error("ack without access");

	property p_version_read;
		s_read(PFID_ARCH_VERSION_ID_OFS) |=> rsp_o.rdata[PFID_DATA_W-1:8] == '0
			&& rsp_o.rdata[7:0] == (PART_PRESENT ? {MAJOR_REV, MINOR_REV} : 8'h00);
	endproperty
	a_version_read: assert property (p_version_read) else $error("version read wrong");

	property p_version_pages;
		s_read(PFID_ARCH_VERSION_ID_OFS) ##1 s_read(PFID_ARCH_VERSION_ID_OFS)
			|=> rsp_o.rdata == $past(rsp_o.rdata);
	endproperty
	a_version_pages: assert property (p_version_pages) else $error("version differs by page");

	property p_cap_read;
		s_read(PFID_CACHE_CAPACITY_FEATURE_ID_OFS) |=> rsp_o.rdata[PFID_DATA_W-1:PFID_CAP_W] == '0
			&& (!(PART_PRESENT && CAP_PRESENT) ? rsp_o.rdata == '0 : rsp_o.rdata <= 32'(PFID_CAP_MAX));
	endproperty
	a_cap_read: assert property (p_cap_read) else $error("capacity read wrong");

	property p_por_read;
		s_read(PFID_CACHE_PORTION_FEATURE_ID_OFS) |=> rsp_o.rdata[PFID_DATA_W-1:PFID_POR_W] == '0
			&& (!(PART_PRESENT && POR_PRESENT) ? rsp_o.rdata == '0 : 1'b1);
	endproperty
	a_por_read: assert property (p_por_read) else $error("portion read wrong");

	property p_write_quiet;
		req_i.valid && req_i.write |=> rsp_o.rdata == '0 && $stable(force_nonsecure_partition_o);
	endproperty
	a_write_quiet: assert property (p_write_quiet) else $error("write had an effect");

	// First edge after release still shows the reset value, so it is skipped
	property p_force_version;
		$past(rst_n_i) |-> force_nonsecure_partition_o == (PART_PRESENT && VER_EARLY);
	endproperty
	a_force_version: assert property (p_force_version) else $error("forcing mismatches version");

	// Group must cover the bitmap with no spare word
	property p_count_bound;
		$past(rst_n_i) |-> 32'(bitmap_reg_count_o) <= PFID_BITMAP_REGS_MAX
			&& (!(PART_PRESENT && POR_PRESENT) ? bitmap_reg_count_o == '0
				: 32'(bitmap_reg_count_o) * PFID_BITMAP_WORD >= 32'($past(por_wd_sec))
				&& 32'(bitmap_reg_count_o) * PFID_BITMAP_WORD
					< 32'($past(por_wd_sec)) + PFID_BITMAP_WORD);
	endproperty
	a_count_bound: assert property (p_count_bound) else $error("bitmap group size wrong");
endmodule : pfid_regs
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking testbench of the partition feature ID register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import pfid_pkg::*;
	// Version pair 0.1, the only one that carries the forcing output
	localparam logic [3:0] MAJ = 4'h0;
	localparam logic [3:0] MIN = 4'h1;
	localparam logic [11:0] CAP_S = {6'h10, 6'h01};
	localparam logic [11:0] CAP_N = {6'h05, 6'h0c};
	// Widths 33 and 32768 hit the two bitmap group boundaries
	localparam logic [31:0] POR_S = {16'h8000, 16'h0021};
	localparam logic [31:0] POR_N = {16'h0001, 16'h0020};
	// Third bank: version 1.1, portion control only, selector ignored
	localparam logic [3:0] MAJ_C = 4'h1;
	localparam logic [3:0] MIN_C = 4'h1;
	localparam logic [15:0] POR_CS = 16'h0041;
	localparam logic [15:0] POR_CN = 16'h0007;
	localparam logic [10:0] CNT_C = 11'((int'(POR_CS) + 31) / 32);
	logic clk_sys;
	logic rst_n;
	pfid_req_t req;
	pfid_req_t last;
	pfid_req_t r;
	logic [3:0] sel;
	logic [3:0] last_sel;
	pfid_rsp_t rsp_a;
	pfid_rsp_t rsp_b;
	pfid_rsp_t rsp_c;
	logic frc_a;
	logic frc_b;
	logic frc_c;
	logic [10:0] cnt_a;
	logic [10:0] cnt_b;
	logic [10:0] cnt_c;
	int miscompares = 0;
	int n_checks = 0;
	int seed = 35;

	// Fully featured bank with two instances
	pfid_regs #(.INST_PRESENT(1'b1), .NUM_INST(2), .MAJOR_REV(MAJ), .MINOR_REV(MIN),
		.CAP_WD_SECURE(CAP_S), .CAP_WD_NONSECURE(CAP_N),
		.POR_WD_SECURE(POR_S), .POR_WD_NONSECURE(POR_N)) i_pfid_regs (
		.clk_sys_i(clk_sys), .rst_n_i(rst_n), .req_i(req),
		.resource_instance_selector_i(sel), .rsp_o(rsp_a),
		.force_nonsecure_partition_o(frc_a), .bitmap_reg_count_o(cnt_a));
	// Bank with the whole extension configured away
	pfid_regs #(.PART_PRESENT(1'b0), .CAP_PRESENT(1'b0), .POR_PRESENT(1'b0)) i_pfid_regs_off (
		.clk_sys_i(clk_sys), .rst_n_i(rst_n), .req_i(req),
		.resource_instance_selector_i(sel), .rsp_o(rsp_b),
		.force_nonsecure_partition_o(frc_b), .bitmap_reg_count_o(cnt_b));
	// Partitioning present but capacity control absent, no instances
	pfid_regs #(.MAJOR_REV(MAJ_C), .MINOR_REV(MIN_C), .CAP_PRESENT(1'b0),
		.POR_WD_SECURE(POR_CS), .POR_WD_NONSECURE(POR_CN)) i_pfid_regs_por (
		.clk_sys_i(clk_sys), .rst_n_i(rst_n), .req_i(req),
		.resource_instance_selector_i(sel), .rsp_o(rsp_c),
		.force_nonsecure_partition_o(frc_c), .bitmap_reg_count_o(cnt_c));

	// Clock at 125 MHz
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// Read data the full bank must return for one request
	function automatic logic [31:0] exp_rd(pfid_req_t q, logic [3:0] s);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (q.valid && !q.write) begin
			if (q.addr == PFID_ARCH_VERSION_ID_OFS) v = {24'h00_0000, MAJ, MIN};
			else if (s < 4'h2 && q.addr == PFID_CACHE_PORTION_FEATURE_ID_OFS)
				v = {16'h0000, q.secure ? POR_S[s*16 +: 16] : POR_N[s*16 +: 16]};
			else if (s < 4'h2 && q.addr == PFID_CACHE_CAPACITY_FEATURE_ID_OFS)
				v = {26'h000_0000, q.secure ? CAP_S[s*6 +: 6] : CAP_N[s*6 +: 6]};
		end
		return v;
	endfunction : exp_rd

	// Read data of the third bank; its selector must have no effect
	function automatic logic [31:0] exp_rd_c(pfid_req_t q);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (q.valid && !q.write) begin
			if (q.addr == PFID_ARCH_VERSION_ID_OFS) v = {24'h00_0000, MAJ_C, MIN_C};
			else if (q.addr == PFID_CACHE_PORTION_FEATURE_ID_OFS)
				v = {16'h0000, q.secure ? POR_CS : POR_CN};
		end
		return v;
	endfunction : exp_rd_c

	// Bitmap register group size, rounded up to whole words
	function automatic logic [10:0] exp_cnt(logic [3:0] s);
		if (s >= 4'h2) return 11'h000;
		return 11'((int'(POR_S[s*16 +: 16]) + 31) / 32);
	endfunction : exp_cnt

	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_sim

	// Present one request; the answer seen now belongs to the previous one
	task automatic issue(pfid_req_t q, logic [3:0] s);
		@(posedge clk_sys);
		req <= q;
		sel <= s;
		@(negedge clk_sys);
		chk("rdata_a", rsp_a.rdata, exp_rd(last, last_sel));
		chk("ack_a", {31'h0, rsp_a.ack}, {31'h0, last.valid});
		chk("rdata_b", rsp_b.rdata, 32'h0000_0000);
		chk("ack_b", {31'h0, rsp_b.ack}, {31'h0, last.valid});
		chk("cnt_a", {21'h0, cnt_a}, {21'h0, exp_cnt(last_sel)});
		chk("cnt_b", {21'h0, cnt_b}, 32'h0000_0000);
		chk("rdata_c", rsp_c.rdata, exp_rd_c(last));
		chk("ack_c", {31'h0, rsp_c.ack}, {31'h0, last.valid});
		chk("cnt_c", {21'h0, cnt_c}, {21'h0, CNT_C});
		chk("force", {29'h0, frc_a, frc_b, frc_c}, 32'h0000_0004);
		last = q;
		last_sel = s;
	endtask : issue

	// Watchdog sized well above the planned run
	initial begin
		#(2000 * 8);
		miscompares++;
		end_sim;
	end

	initial begin
		req = '0;
		sel = 4'h0;
		last = '0;
		last_sel = 4'h0;
		rst_n = 1'b0;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		// Back to back: write then read, all pages, selectors and an unmapped offset
		for (int s = 0; s < 3; s++) begin
			for (int k = 0; k < 10; k++) begin
				r.valid = 1'b1;
				r.write = (k % 5 == 0);
				r.secure = k[0];
				r.wdata = 32'hffff_ffff;
				case (k % 5)
					0, 1: r.addr = PFID_ARCH_VERSION_ID_OFS;
					2: r.addr = PFID_CACHE_PORTION_FEATURE_ID_OFS;
					3: r.addr = PFID_CACHE_CAPACITY_FEATURE_ID_OFS;
					default: r.addr = 12'h3fc;
				endcase
				issue(r, 4'(s));
			end
		end
		// Random traffic with idle gaps and out-of-range selectors
		for (int i = 0; i < 400; i++) begin
			r.valid = ($random(seed) % 8) != 0;
			r.write = ($random(seed) % 4) == 0;
			r.secure = $random(seed);
			r.wdata = $random(seed);
			case ($random(seed) & 3)
				0: r.addr = PFID_ARCH_VERSION_ID_OFS;
				1: r.addr = PFID_CACHE_PORTION_FEATURE_ID_OFS;
				2: r.addr = PFID_CACHE_CAPACITY_FEATURE_ID_OFS;
				default: r.addr = 12'($random(seed)) & 12'hffc;
			endcase
			issue(r, 4'($random(seed)));
		end
		// Second reset in mid-run clears every output
		issue('0, 4'h1);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		@(negedge clk_sys);
		chk("rst_cnt", {10'h000, cnt_a, cnt_b}, 32'h0000_0000);
		chk("rst_misc", {17'h0_0000, cnt_c, frc_a, frc_b, frc_c, rsp_a.ack}, 32'h0000_0000);
		chk("rst_rdata", rsp_a.rdata, 32'h0000_0000);
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		r = '0;
		issue(r, 4'h1);
		issue(r, 4'h0);
		end_sim;
	end
endmodule : testbench
`default_nettype wire
